/* hdl/acr_pkg.sv */
//------------------------------------------------------------------------------
// Purpose : Shared constants for the converter readout link (both ends)
// Assumes : 10 MHz system clock on both ends
// Notes   : Times are kept as printed; cycle counts derive from them
//------------------------------------------------------------------------------
`default_nettype none

package acr_pkg;

   //---------------------------------------------------------------------------
   // Clock and data format
   //---------------------------------------------------------------------------
   localparam real CLK_PERIOD_NS = 100.0;
   localparam int  RESULT_W      = 16;
   localparam int  BITCNT_W      = 5;
   // Two synchroniser stages plus the edge register
   localparam int  SYNC_CYC      = 3;

   //---------------------------------------------------------------------------
   // Printed times
   //---------------------------------------------------------------------------
   localparam real T_CONV_FAST_MIN_NS = 500.0;
   localparam real T_CONV_FAST_MAX_NS = 710.0;
   localparam real T_CONV_SLOW_MIN_US = 0.5;
   localparam real T_CONV_SLOW_MAX_US = 1.6;
   localparam real T_CNVH_NS          = 10.0;
   localparam real T_SCK_SEL_NS       = 10.5;
   localparam real T_SCK_CHAIN_NS     = 11.5;
   localparam real T_CYC_FAST_US      = 1.0;
   localparam real T_CYC_SLOW_US      = 2.0;
   localparam real T_ACQ_FAST_NS      = 290.0;

   //---------------------------------------------------------------------------
   // Cycle conversions: least times round up, longest times round down
   //---------------------------------------------------------------------------
   function automatic int cyc_up(input real t_ns);
      int c;
      c = int'($ceil(t_ns / CLK_PERIOD_NS));
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int cyc_dn(input real t_ns);
      int c;
      c = int'($floor(t_ns / CLK_PERIOD_NS));
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CONV_FAST_MIN_CYC = cyc_up(T_CONV_FAST_MIN_NS);
   localparam int CONV_FAST_MAX_CYC = cyc_dn(T_CONV_FAST_MAX_NS);
   localparam int CONV_SLOW_MIN_CYC = cyc_up(T_CONV_SLOW_MIN_US * 1000.0);
   localparam int CONV_SLOW_MAX_CYC = cyc_dn(T_CONV_SLOW_MAX_US * 1000.0);
   localparam int CNVH_CYC          = cyc_up(T_CNVH_NS);
   localparam int SCK_SEL_CYC       = cyc_up(T_SCK_SEL_NS);
   localparam int SCK_CHAIN_CYC     = cyc_up(T_SCK_CHAIN_NS);
   localparam int CYC_FAST_CYC      = cyc_up(T_CYC_FAST_US * 1000.0);
   localparam int CYC_SLOW_CYC      = cyc_up(T_CYC_SLOW_US * 1000.0);
   localparam int ACQ_FAST_CYC      = cyc_up(T_ACQ_FAST_NS);

endpackage : acr_pkg

`default_nettype wire

/* hdl/acr_link_if.sv */
//------------------------------------------------------------------------------
// Purpose : Pin-level link between converter end and host end
// Assumes : Serial output line is pulled low while released
// Notes   : Only the interface resolves the shared serial line
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

interface acr_link_if;
   logic cnv;
   logic sck;
   logic chain_select_in;
   logic serial_result_out;
   logic serial_result_oe;
   logic serial_line;

   // Released line reads low (weak pull-down on the board)
   assign serial_line = serial_result_oe & serial_result_out;

   modport dev  (input cnv, input sck, input chain_select_in,
                 output serial_result_out, output serial_result_oe);
   modport host (output cnv, output sck, output chain_select_in,
                 input serial_line);
endinterface : acr_link_if

`default_nettype wire

/* hdl/acr_dev.sv */
//------------------------------------------------------------------------------
// Purpose : Converter end: conversion timing and serial result readout
// Assumes : Link pins are asynchronous to i_mclk and pass two flip-flops
// Notes   : Pin timings in the ns range are met only as closely as the
//           100 ns sampling clock allows
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module acr_dev
   import acr_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b1,
   parameter bit BUSY_IND     = 1'b0
)(
   input  wire logic                i_mclk,
   input  wire logic                i_arst_n,
   acr_link_if.dev                  link,
   input  wire logic [RESULT_W-1:0] i_sample,
   output logic                     o_conv_done,
   output logic                     o_busy,
   output logic                     o_chain_mode
);

   //---------------------------------------------------------------------------
   // Conversion length
   //---------------------------------------------------------------------------
   // Pin edge to internal start costs SYNC_CYC, so the count is trimmed to
   // land inside the window measured from the pin edge.
   localparam int CONV_MAX_CYC = FAST_VARIANT ? CONV_FAST_MAX_CYC : CONV_SLOW_MAX_CYC;
   localparam int CONV_MIN_CYC = FAST_VARIANT ? CONV_FAST_MIN_CYC : CONV_SLOW_MIN_CYC;
   localparam int CONV_CYC     = CONV_MAX_CYC - SYNC_CYC;

   if ((CONV_CYC < 1) || (CONV_CYC + SYNC_CYC < CONV_MIN_CYC) || (CONV_CYC > 31))
   begin : g_bad_conv
      $error("acr_dev: conversion count cannot meet its window");
   end

   typedef enum logic [3:0] {
      D_IDLE  = 4'b0001,
      D_CONV  = 4'b0010,
      D_SHIFT = 4'b0100,
      D_DONE  = 4'b1000
   } acr_dev_state_e;

   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   // Bit order: 2 = convert, 1 = shift clock, 0 = chain/select
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic [2:0] prev_reg;
   logic       cnv_s;
   logic       sck_s;
   logic       csel_s;
   logic       cnv_rise;
   logic       sck_fall;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
         prev_reg <= 3'h0;
      end
      else
      begin
         meta_reg <= {link.cnv, link.sck, link.chain_select_in};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign cnv_s    = sync_reg[2];
   assign sck_s    = sync_reg[1];
   assign csel_s   = sync_reg[0];
   assign cnv_rise = cnv_s & ~prev_reg[2];
   assign sck_fall = ~sck_s & prev_reg[1];

   //---------------------------------------------------------------------------
   // Conversion and shift state
   //---------------------------------------------------------------------------
   acr_dev_state_e        state_reg;
   acr_dev_state_e        state_next;
   logic [BITCNT_W-1:0]   cnt_reg;
   logic [BITCNT_W-1:0]   cnt_next;
   logic [BITCNT_W-1:0]   bits_reg;
   logic [BITCNT_W-1:0]   bits_next;
   logic [RESULT_W-1:0]   shreg_reg;
   logic [RESULT_W-1:0]   shreg_next;
   logic                  chain_reg;
   logic                  chain_next;
   logic                  lead_reg;
   logic                  lead_next;
   logic                  done_reg;
   logic                  done_next;
   logic                  sdo_reg;
   logic                  sdo_next;
   logic                  oe_reg;
   logic                  oe_next;

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      bits_next  = bits_reg;
      shreg_next = shreg_reg;
      chain_next = chain_reg;
      lead_next  = lead_reg;
      done_next  = 1'b0;

      unique case (state_reg)
         D_IDLE, D_DONE:
         begin
            state_next = state_reg;
         end
         D_CONV:
         begin
            if (cnt_reg == '0)
            begin
               // Result latched at the end of the conversion window
               state_next = D_SHIFT;
               shreg_next = i_sample;
               bits_next  = '0;
               lead_next  = BUSY_IND & chain_reg;
               done_next  = 1'b1;
            end
            else
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         D_SHIFT:
         begin
            if (sck_fall)
            begin
               if (lead_reg)
               begin
                  // First fall after the busy flag only clears it
                  lead_next = 1'b0;
               end
               else
               begin
                  // Next bit after each fall; chain input enters at the bottom
                  shreg_next = {shreg_reg[RESULT_W-2:0], chain_reg & csel_s};
                  if (bits_reg != 5'h1f)
                  begin
                     bits_next = bits_reg + 5'h01;
                  end
                  if (!chain_reg && (bits_reg == 5'(RESULT_W - 1)))
                  begin
                     state_next = D_DONE;
                  end
               end
            end
         end
      endcase

      // A new convert edge restarts from any state and picks the mode
      if (cnv_rise)
      begin
         state_next = D_CONV;
         cnt_next   = 5'(CONV_CYC - 1);
         chain_next = ~csel_s;
         lead_next  = 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Serial output drive
   //---------------------------------------------------------------------------
   always_comb
   begin
      sdo_next = shreg_next[RESULT_W-1];
      oe_next  = 1'b0;
      if (chain_next)
      begin
         // Chain output is always driven once a conversion has begun
         oe_next = (state_next != D_IDLE);
         if (lead_next)
         begin
            sdo_next = csel_s;
         end
      end
      else if (state_next == D_SHIFT)
      begin
         // Either select pin low enables; release when both high
         oe_next = ~cnv_s | ~csel_s;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_reg <= D_IDLE;
         cnt_reg   <= '0;
         bits_reg  <= '0;
         shreg_reg <= '0;
         chain_reg <= 1'b0;
         lead_reg  <= 1'b0;
         done_reg  <= 1'b0;
         sdo_reg   <= 1'b0;
         oe_reg    <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         bits_reg  <= bits_next;
         shreg_reg <= shreg_next;
         chain_reg <= chain_next;
         lead_reg  <= lead_next;
         done_reg  <= done_next;
         sdo_reg   <= sdo_next;
         oe_reg    <= oe_next;
      end
   end

   //---------------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------------
   assign link.serial_result_out = sdo_reg;
   assign link.serial_result_oe  = oe_reg;
   assign o_conv_done            = done_reg;
   assign o_busy                 = (state_reg == D_CONV);
   assign o_chain_mode           = chain_reg;

endmodule // acr_dev

`default_nettype wire

/* hdl/acr_host.sv */
//------------------------------------------------------------------------------
// Purpose : Host end: starts conversions and reads the serial result
// Assumes : One converter on the link; shift clock made here by a divider
// Notes   : Bits are sampled just before the falling edge this end drives
//------------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module acr_host
   import acr_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b1,
   parameter bit BUSY_IND     = 1'b0,
   parameter int HALF_CYC     = 4
)(
   input  wire logic                i_mclk,
   input  wire logic                i_arst_n,
   acr_link_if.host                 link,
   input  wire logic                i_start,
   input  wire logic                i_chain_mode,
   output logic                     o_ready,
   output logic                     o_valid,
   output logic [RESULT_W-1:0]      o_result
);

   localparam int CONV_MAX_CYC = FAST_VARIANT ? CONV_FAST_MAX_CYC : CONV_SLOW_MAX_CYC;
   localparam int WAIT_CYC     = CONV_MAX_CYC + SYNC_CYC + 1;
   localparam int CYC_CYC      = FAST_VARIANT ? CYC_FAST_CYC : CYC_SLOW_CYC;

   // Device sees edges through two flip-flops, so each phase needs 3 cycles
   if ((HALF_CYC < 3) || (HALF_CYC > 127) || (2 * HALF_CYC < SCK_CHAIN_CYC) ||
       (2 * HALF_CYC < SCK_SEL_CYC) || (WAIT_CYC < CNVH_CYC) || (WAIT_CYC > 31))
   begin : g_bad_param
      $error("acr_host: shift clock or wait count out of range");
   end

   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_SETUP = 4'b0010,
      H_CONV  = 4'b0100,
      H_SHIFT = 4'b1000
   } acr_host_state_e;

   //---------------------------------------------------------------------------
   // Serial line synchroniser
   //---------------------------------------------------------------------------
   logic meta_reg;
   logic line_s_reg;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_reg   <= 1'b0;
         line_s_reg <= 1'b0;
      end
      else
      begin
         meta_reg   <= link.serial_line;
         line_s_reg <= meta_reg;
      end
   end

   //---------------------------------------------------------------------------
   // Sequencer
   //---------------------------------------------------------------------------
   acr_host_state_e       state_reg;
   acr_host_state_e       state_next;
   logic [BITCNT_W-1:0]   cnt_reg;
   logic [BITCNT_W-1:0]   cnt_next;
   logic [7:0]            ph_reg;
   logic [7:0]            ph_next;
   logic [7:0]            gap_reg;
   logic [7:0]            gap_next;
   logic [BITCNT_W-1:0]   bits_reg;
   logic [BITCNT_W-1:0]   bits_next;
   logic [RESULT_W-1:0]   res_reg;
   logic [RESULT_W-1:0]   res_next;
   logic                  chain_reg;
   logic                  chain_next;
   logic                  cnv_reg;
   logic                  cnv_next;
   logic                  sck_reg;
   logic                  sck_next;
   logic                  csel_reg;
   logic                  csel_next;
   logic                  valid_reg;
   logic                  valid_next;
   logic [BITCNT_W-1:0]   nbits;

   // Busy chain readout carries one leading flag bit before the data
   assign nbits = (chain_reg && BUSY_IND) ? 5'(RESULT_W + 1) : 5'(RESULT_W);

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      ph_next    = ph_reg;
      bits_next  = bits_reg;
      res_next   = res_reg;
      chain_next = chain_reg;
      cnv_next   = cnv_reg;
      sck_next   = sck_reg;
      csel_next  = csel_reg;
      valid_next = 1'b0;
      gap_next   = (gap_reg != 8'h00) ? gap_reg - 8'h01 : 8'h00;

      unique case (state_reg)
         H_IDLE:
         begin
            // Start refused until the conversion spacing has run out
            if (i_start && (gap_reg == 8'h00))
            begin
               state_next = H_SETUP;
               chain_next = i_chain_mode;
               csel_next  = ~i_chain_mode;
               gap_next   = 8'(CYC_CYC - 1);
            end
         end
         H_SETUP:
         begin
            // Shift clock stays low across the convert edge
            state_next = H_CONV;
            cnv_next   = 1'b1;
            cnt_next   = 5'(WAIT_CYC - 1);
         end
         H_CONV:
         begin
            // Convert held high for the whole wait
            if (cnt_reg == '0)
            begin
               state_next = H_SHIFT;
               ph_next    = 8'h00;
               bits_next  = '0;
               // Select mode enables output; busy chain raises the flag input
               csel_next  = chain_reg & BUSY_IND;
            end
            else
            begin
               cnt_next = cnt_reg - 5'h01;
            end
         end
         H_SHIFT:
         begin
            // Divider: low half then high half, period 2*HALF_CYC
            ph_next  = ph_reg + 8'h01;
            sck_next = (ph_reg >= 8'(HALF_CYC - 1)) && (ph_reg != 8'(2 * HALF_CYC - 1));
            if (ph_reg == 8'(2 * HALF_CYC - 1))
            begin
               ph_next   = 8'h00;
               res_next  = {res_reg[RESULT_W-2:0], line_s_reg};
               bits_next = bits_reg + 5'h01;
               if (bits_next == nbits)
               begin
                  state_next = H_IDLE;
                  cnv_next   = 1'b0;
                  csel_next  = 1'b0;
                  valid_next = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_reg <= H_IDLE;
         cnt_reg   <= '0;
         ph_reg    <= 8'h00;
         gap_reg   <= 8'h00;
         bits_reg  <= '0;
         res_reg   <= '0;
         chain_reg <= 1'b0;
         cnv_reg   <= 1'b0;
         sck_reg   <= 1'b0;
         csel_reg  <= 1'b0;
         valid_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         ph_reg    <= ph_next;
         gap_reg   <= gap_next;
         bits_reg  <= bits_next;
         res_reg   <= res_next;
         chain_reg <= chain_next;
         cnv_reg   <= cnv_next;
         sck_reg   <= sck_next;
         csel_reg  <= csel_next;
         valid_reg <= valid_next;
      end
   end

   //---------------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------------
   assign link.cnv             = cnv_reg;
   assign link.sck             = sck_reg;
   assign link.chain_select_in = csel_reg;
   assign o_ready              = (state_reg == H_IDLE) && (gap_reg == 8'h00);
   assign o_valid              = valid_reg;
   assign o_result             = res_reg;

endmodule // acr_host

`default_nettype wire

/* test/acr_chk.sv */
//---------------------------------------------------------
// Purpose : Link checks between converter and host ends
// Assumes : Fast variant, busy flag in chain mode, shift divider of 4
// Notes   : ns figures are judged at 100 ns resolution
//---------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module acr_chk
   import acr_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic cnv,
   input wire logic sck,
   input wire logic chain_select_in,
   input wire logic serial_result_out,
   input wire logic serial_result_oe,
   input wire logic serial_line
);
   //----------
   // Helper state
   //----------
   logic       cnv_q_reg, sck_q_reg, sel_reg, sel_next;
   logic [4:0] falls_reg, falls_next;
   logic [7:0] gap_reg, gap_next;

   // Gap saturates so a long idle never wraps into a false spacing fault
   always_comb
   begin
      sel_next   = sel_reg;
      falls_next = falls_reg;
      gap_next   = (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h01;
      if (cnv && !cnv_q_reg)
      begin
         sel_next   = chain_select_in;
         falls_next = 5'h00;
         gap_next   = 8'h01;
      end
      else if (sck_q_reg && !sck && falls_reg != 5'h1f)
      begin
         falls_next = falls_reg + 5'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         {cnv_q_reg, sck_q_reg, sel_reg, falls_reg, gap_reg} <= {3'b001, 5'h00, 8'hff};
      end
      else
      begin
         {cnv_q_reg, sck_q_reg, sel_reg, falls_reg, gap_reg} <= {cnv, sck, sel_next, falls_next, gap_next};
      end
   end

   //----------
   // Assertions
   //----------
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   AST_CNV_HELD: assert property ($rose(cnv) |-> cnv [*8])
      else $error("convert strobe dropped early");
   AST_MODE_HOLD: assert property ($rose(cnv) |-> $stable(chain_select_in))
      else $error("select moved at convert edge");
   AST_SCK_STILL: assert property ($rose(cnv) |-> $stable(sck) ##1 !sck [*7])
      else $error("shift clock moved during conversion");
   AST_SCK_LOW: assert property ($fell(sck) |-> !sck [*4])
      else $error("shift clock low phase short");
   AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*3])
      else $error("shift clock high phase short");
   AST_SPACING: assert property ($rose(cnv) |-> gap_reg >= CYC_FAST_CYC)
      else $error("conversions too close");
   AST_EARLY_QUIET: assert property (($rose(cnv) && chain_select_in) |-> ##4 !serial_result_oe)
      else $error("output driven before result ready");
   AST_ENABLE: assert property (($fell(chain_select_in) && cnv && sel_reg) |-> ##[1:5] serial_result_oe)
      else $error("output not enabled by select");
   AST_BIT_HOLD: assert property (($fell(sck) && serial_result_oe) |-> $stable(serial_line) [*2])
      else $error("bit changed at shift fall");
   AST_RELEASE: assert property (($fell(sck) && sel_reg && falls_reg == 5'h0f) |-> ##[1:5] !serial_result_oe)
      else $error("output not released after last bit");
   AST_CHAIN_DRIVE: assert property (($rose(cnv) && !chain_select_in) |-> ##[1:8] serial_result_oe)
      else $error("chain mode output not driven");
   AST_BUSY_FLAG: assert property (($rose(chain_select_in) && cnv && !sel_reg) |-> ##[1:5] serial_line)
      else $error("busy flag did not follow chain input");
   // Busy chain: lead fall plus 16 data falls, so the 17th fall shows the input
   AST_CHAIN_PASS: assert property (
      ($fell(sck) && !sel_reg && falls_reg == 5'h10 && $past(chain_select_in)) |-> ##3 serial_line)
      else $error("chain input not reproduced after 16 shifts");

   C_SEL: cover property ($rose(cnv) && chain_select_in);
   C_CHAIN: cover property ($rose(cnv) && !chain_select_in);
   C_LAST: cover property ($fell(sck) && falls_reg == 5'h0f);
   C_FLAG: cover property ($rose(chain_select_in) && cnv && !sel_reg);

endmodule // acr_chk

`default_nettype wire

/* test/test_adc_conversion_serial_readout.sv */
//---------------------------------------------------------
// Purpose : Both link ends joined, results checked end to end
// Assumes : Fast variant, busy flag on (chain reads 17 falls), default divider
// Notes   : Select conversions run first, chain ones after
//---------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module test_adc_conversion_serial_readout
   import acr_pkg::*;
;
   logic        i_mclk, i_arst_n, i_start, i_chain_mode;
   logic [15:0] i_sample, o_result, wire_word;
   logic        o_ready, o_valid, o_conv_done, o_busy, o_chain_mode;
   logic        sck_prev, cnv_prev, busy_seen;
   logic [16:0] notes[$];
   logic [16:0] note;
   int          fail_count, samples_checked, cycles, conv_t, seed;

   acr_link_if link ();

   // Busy flag on so chain pass-through and the flag bit are exercised
   acr_dev #(.BUSY_IND(1'b1)) acr_dev_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link), .i_sample(i_sample),
      .o_conv_done(o_conv_done), .o_busy(o_busy), .o_chain_mode(o_chain_mode));
   acr_host #(.BUSY_IND(1'b1)) acr_host_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link), .i_start(i_start),
      .i_chain_mode(i_chain_mode), .o_ready(o_ready), .o_valid(o_valid), .o_result(o_result));
   acr_chk acr_chk_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .cnv(link.cnv), .sck(link.sck),
      .chain_select_in(link.chain_select_in), .serial_result_out(link.serial_result_out),
      .serial_result_oe(link.serial_result_oe), .serial_line(link.serial_line));

   //----------
   // Compare and close
   //----------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   //----------
   // Driver: one conversion, plus a start poked during readout
   //----------
   task automatic convert(input logic mode, input logic [15:0] val);
      int n;
      n = 0;
      while (o_ready !== 1'b1 && n < 400)
      begin
         @(posedge i_mclk);
         #10;
         n++;
      end
      i_sample     = val;
      i_chain_mode = mode;
      i_start      = 1'b1;
      notes.push_back({mode, val});
      @(posedge i_mclk);
      #10;
      i_start = 1'b0;
      // A start during readout must be ignored; the flipped mode would show
      repeat (30) @(posedge i_mclk);
      #10;
      i_start      = 1'b1;
      i_chain_mode = ~mode;
      @(posedge i_mclk);
      #10;
      i_start      = 1'b0;
      i_chain_mode = mode;
   endtask

   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         fail_count++;
         conclude();
      end
   end

   //----------
   // Monitor: sampled mid-cycle so all edge updates have landed
   //----------
   always @(negedge i_mclk)
   begin
      if (link.sck === 1'b0 && sck_prev === 1'b1)
      begin
         wire_word = {wire_word[14:0], link.serial_line};
      end
      sck_prev = link.sck;
      conv_t   = (link.cnv === 1'b1 && cnv_prev === 1'b0) ? 0 : conv_t + 1;
      cnv_prev = link.cnv;
      // Busy must have been seen since the convert edge and be gone at result
      busy_seen = (conv_t == 0) ? 1'b0 : (busy_seen | o_busy);
      if (o_conv_done === 1'b1)
      begin
         chk(16'(conv_t >= CONV_FAST_MIN_CYC && conv_t <= CONV_FAST_MAX_CYC), 16'h0001);
         chk({14'h0000, o_busy, busy_seen}, 16'h0001);
      end
      if (o_valid === 1'b1)
      begin
         note = (notes.size() > 0) ? notes.pop_front() : 'x;
         chk(o_result, note[15:0]);
         chk(wire_word, note[15:0]);
         chk({15'h0000, o_chain_mode}, {15'h0000, note[16]});
      end
   end

   initial
   begin
      int n;
      seed = 32'hc074;
      {fail_count, samples_checked, cycles, conv_t} = '0;
      {i_arst_n, i_start, i_chain_mode, sck_prev, cnv_prev, busy_seen} = '0;
      i_sample  = 16'h0000;
      wire_word = 16'h0000;
      repeat (4) @(posedge i_mclk);
      #10;
      i_arst_n = 1'b1;
      convert(1'b0, 16'h8000);
      convert(1'b0, 16'h0001);
      for (int k = 0; k < 8; k++)
      begin
         convert(k >= 4, 16'($random(seed)));
      end
      n = 0;
      while (notes.size() != 0 && n < 400)
      begin
         @(posedge i_mclk);
         n++;
      end
      chk(16'(notes.size()), 16'h0000);
      conclude();
   end

endmodule // test_adc_conversion_serial_readout

`default_nettype wire
